// ===== dst_pkg.sv
// constants for the display sync timing block
package dst_pkg;
	// ==========================================
	// register byte offsets
	localparam logic [15:0] CRT_HSYNC_POSITION_OFS = 16'h8338;
	localparam logic [15:0] PANEL_HSYNC_POSITION_OFS = 16'h833C;
	localparam logic [15:0] FRAME_LINE_TOTAL_OFS = 16'h8340;
	localparam logic [15:0] LINE_PIXEL_TOTAL_OFS = 16'h8350;
	localparam logic [15:0] SCAN_CONTROL_OFS = 16'h8354;
	localparam logic [15:0] SCAN_STATUS_OFS = 16'h8358;
	// ==========================================
	// field positions
	localparam int CHAR_LO = 3;
	localparam int CHAR_HI = 10;
	localparam int CHAR_END_LO = 19;
	localparam int CHAR_END_HI = 26;
	localparam int LOW_LO = 0;
	localparam int LOW_HI = 10;
	localparam int HIGH_LO = 16;
	localparam int HIGH_HI = 26;
	localparam int PIX_SHIFT = 3;
	// ==========================================
	// masks of defined bits
	localparam logic [31:0] CRT_MASK = 32'h07F807F8;
	localparam logic [31:0] PAIR_MASK = 32'h07FF07FF;
	localparam logic [31:0] CTRL_MASK = 32'h00000001;
	// ==========================================
	// values after reset and count step
	localparam logic [31:0] REG_RESET = 32'h00000000;
	localparam logic [10:0] COUNT_RESET = 11'h000;
	localparam logic [10:0] COUNT_ONE = 11'h001;
	// ==========================================
	// pixel divider
	localparam int PIX_DIV_DEFAULT = 1;
endpackage

// ===== dst_sync_if.sv
// carrier between scan control and one sync generator
`timescale 1ns/1ns
interface dst_sync_if;
	logic pixEn;
	logic [10:0] count;
	logic [10:0] beginPos;
	logic [10:0] finishPos;
	logic syncOut;
	modport gen (input pixEn, input count, input beginPos, input finishPos, output syncOut);
	modport ctl (output pixEn, output count, output beginPos, output finishPos, input syncOut);
endinterface

// ===== dst_sync_gen.sv
// one sync pulse generator from a position counter
`timescale 1ns/1ns
module dst_sync_gen (
	input wire logic clk_sys,
	input wire logic rst_n,
	dst_sync_if.gen sif
);
	logic sync_r;
	logic hitBegin;
	logic hitFinish;

	// ==========================================
	// compare against value plus one
	assign hitBegin = (sif.count == 11'(sif.beginPos + dst_pkg::COUNT_ONE));
	assign hitFinish = (sif.count == 11'(sif.finishPos + dst_pkg::COUNT_ONE));

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sync_r <= 1'b0;
		end else if (sif.pixEn) begin
			if (hitFinish) begin
				sync_r <= 1'b0;
			end else if (hitBegin) begin
				sync_r <= 1'b1;
			end
		end
	end

	assign sif.syncOut = sync_r;
endmodule // dst_sync_gen

// ===== dst_display_sync_timing.sv
// raster sync timing with apb register access
// Contract
// - crt sync starts at char start plus one
// - crt sync ends at char end plus one
// - crt positions on eight pixel boundaries
// - panel sync starts at pixel start plus one
// - panel sync ends at pixel end plus one
// - frame scans programmed total plus one lines
// - active line count marks displayed lines
`timescale 1ns/1ns
module dst_display_sync_timing #(
	parameter int PIX_DIV = dst_pkg::PIX_DIV_DEFAULT
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic crtHsync,
	output logic panelHsync,
	output logic frameStart,
	output logic lineActive
);
	logic [31:0] crtPos_r;
	logic [31:0] panelPos_r;
	logic [31:0] frameTotal_r;
	logic [31:0] lineTotal_r;
	logic [31:0] control_r;
	logic [31:0] prdata_r;
	logic [10:0] pixCnt_r;
	logic [10:0] lineCnt_r;
	logic [15:0] div_r;
	logic frameStart_r;
	logic crtPrev_r;
	logic pixEn;
	logic scanOn;
	logic wrEn;
	logic rdEn;
	logic mapped;
	logic crtEdge;

	dst_sync_if crtIf ();
	dst_sync_if panelIf ();

	function automatic logic isMapped(input logic [15:0] a);
		isMapped = (a == dst_pkg::CRT_HSYNC_POSITION_OFS) ||
			(a == dst_pkg::PANEL_HSYNC_POSITION_OFS) ||
			(a == dst_pkg::FRAME_LINE_TOTAL_OFS) ||
			(a == dst_pkg::LINE_PIXEL_TOTAL_OFS) ||
			(a == dst_pkg::SCAN_CONTROL_OFS) ||
			(a == dst_pkg::SCAN_STATUS_OFS);
	endfunction

	// ==========================================
	// apb slave, zero wait states
	assign mapped = isMapped(paddr);
	assign wrEn = psel && penable && pwrite && mapped;
	assign rdEn = psel && !penable && !pwrite;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign prdata = prdata_r;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			crtPos_r <= dst_pkg::REG_RESET;
			panelPos_r <= dst_pkg::REG_RESET;
			frameTotal_r <= dst_pkg::REG_RESET;
			lineTotal_r <= dst_pkg::REG_RESET;
			control_r <= dst_pkg::REG_RESET;
		end else if (wrEn) begin
			case (paddr)
				dst_pkg::CRT_HSYNC_POSITION_OFS: crtPos_r <= pwdata & dst_pkg::CRT_MASK;
				dst_pkg::PANEL_HSYNC_POSITION_OFS: panelPos_r <= pwdata & dst_pkg::PAIR_MASK;
				dst_pkg::FRAME_LINE_TOTAL_OFS: frameTotal_r <= pwdata & dst_pkg::PAIR_MASK;
				dst_pkg::LINE_PIXEL_TOTAL_OFS: lineTotal_r <= pwdata & dst_pkg::PAIR_MASK;
				dst_pkg::SCAN_CONTROL_OFS: control_r <= pwdata & dst_pkg::CTRL_MASK;
				default: control_r <= control_r;
			endcase
		end
	end

	// read data captured in setup cycle
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			prdata_r <= dst_pkg::REG_RESET;
		end else if (rdEn) begin
			case (paddr)
				dst_pkg::CRT_HSYNC_POSITION_OFS: prdata_r <= crtPos_r;
				dst_pkg::PANEL_HSYNC_POSITION_OFS: prdata_r <= panelPos_r;
				dst_pkg::FRAME_LINE_TOTAL_OFS: prdata_r <= frameTotal_r;
				dst_pkg::LINE_PIXEL_TOTAL_OFS: prdata_r <= lineTotal_r;
				dst_pkg::SCAN_CONTROL_OFS: prdata_r <= control_r;
				dst_pkg::SCAN_STATUS_OFS: prdata_r <= {5'h00, lineCnt_r, 5'h00, pixCnt_r};
				default: prdata_r <= dst_pkg::REG_RESET;
			endcase
		end
	end

	// ==========================================
	// pixel rate enable
	assign scanOn = control_r[0];
	assign pixEn = scanOn && (div_r == 16'(PIX_DIV - 1));

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			div_r <= 16'h0000;
		end else if (!scanOn || pixEn) begin
			div_r <= 16'h0000;
		end else begin
			div_r <= 16'(div_r + 16'h0001);
		end
	end

	// ==========================================
	// horizontal pixel counter
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pixCnt_r <= dst_pkg::COUNT_RESET;
		end else if (!scanOn) begin
			pixCnt_r <= dst_pkg::COUNT_RESET;
		end else if (pixEn) begin
			if (pixCnt_r >= lineTotal_r[dst_pkg::LOW_HI:dst_pkg::LOW_LO]) begin
				pixCnt_r <= dst_pkg::COUNT_RESET;
			end else begin
				pixCnt_r <= 11'(pixCnt_r + dst_pkg::COUNT_ONE);
			end
		end
	end

	// ==========================================
	// crt sync in character clocks
	assign crtIf.pixEn = pixEn;
	assign crtIf.count = {3'b000, pixCnt_r[dst_pkg::LOW_HI:dst_pkg::PIX_SHIFT]};
	assign crtIf.beginPos = {3'b000, crtPos_r[dst_pkg::CHAR_HI:dst_pkg::CHAR_LO]};
	assign crtIf.finishPos = {3'b000, crtPos_r[dst_pkg::CHAR_END_HI:dst_pkg::CHAR_END_LO]};

	dst_sync_gen crtGen (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.sif(crtIf.gen)
	);

	// ==========================================
	// panel sync in pixels
	assign panelIf.pixEn = pixEn;
	assign panelIf.count = pixCnt_r;
	assign panelIf.beginPos = panelPos_r[dst_pkg::LOW_HI:dst_pkg::LOW_LO];
	assign panelIf.finishPos = panelPos_r[dst_pkg::HIGH_HI:dst_pkg::HIGH_LO];

	dst_sync_gen panelGen (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.sif(panelIf.gen)
	);

	assign crtHsync = crtIf.syncOut;
	assign panelHsync = panelIf.syncOut;

	// ==========================================
	// vertical line counter
	// crt sync rising edge
	assign crtEdge = crtIf.syncOut && !crtPrev_r;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			crtPrev_r <= 1'b0;
		end else begin
			crtPrev_r <= crtIf.syncOut;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			lineCnt_r <= dst_pkg::COUNT_RESET;
			frameStart_r <= 1'b0;
		end else if (!scanOn) begin
			lineCnt_r <= dst_pkg::COUNT_RESET;
			frameStart_r <= 1'b0;
		end else if (crtEdge) begin
			if (lineCnt_r >= frameTotal_r[dst_pkg::HIGH_HI:dst_pkg::HIGH_LO]) begin
				lineCnt_r <= dst_pkg::COUNT_RESET;
				frameStart_r <= 1'b1;
			end else begin
				lineCnt_r <= 11'(lineCnt_r + dst_pkg::COUNT_ONE);
				frameStart_r <= 1'b0;
			end
		end else begin
			frameStart_r <= 1'b0;
		end
	end

	assign frameStart = frameStart_r;
	assign lineActive = scanOn && (lineCnt_r <= frameTotal_r[dst_pkg::LOW_HI:dst_pkg::LOW_LO]);
endmodule // dst_display_sync_timing

// ===== dst_display_sync_timing_sva.sv
// assertions for the display sync timing block
`timescale 1ns/1ns
module dst_display_sync_timing_sva #(
	parameter int PIX_DIV = 1
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic crtHsync,
	input wire logic panelHsync,
	input wire logic frameStart,
	input wire logic lineActive
);
	logic [31:0] pan_r;
	logic [10:0] wid_r;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// ==========================================
	// shadow of panel positions and pulse width
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pan_r <= 32'h00000000;
			wid_r <= 11'h000;
		end else begin
			if (psel && penable && pwrite && paddr == 16'h833C) begin
				pan_r <= pwdata;
			end
			wid_r <= panelHsync ? wid_r + 11'h001 : 11'h000;
		end
	end
	property p_unmap;
		psel && penable && paddr == 16'h8000 |-> pslverr && (pwrite || prdata == 32'h00000000);
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped access not refused");
	property p_map;
		psel && penable && paddr == 16'h833C |-> !pslverr && pready;
	endproperty
	a_map: assert property (p_map) else $error("mapped access refused");
	property p_crtRsv;
		psel && penable && !pwrite && paddr == 16'h8338 |-> (prdata & 32'hF807F807) == 32'h0;
	endproperty
	a_crtRsv: assert property (p_crtRsv) else $error("crt ignored bits read");
	property p_panRsv;
		psel && penable && !pwrite && paddr == 16'h833C |-> (prdata & 32'hF800F800) == 32'h0;
	endproperty
	a_panRsv: assert property (p_panRsv) else $error("panel reserved bits read");
	property p_crtChar;
		$rose(crtHsync) |=> crtHsync [*7];
	endproperty
	a_crtChar: assert property (p_crtChar) else $error("crt sync not char wide");
	property p_panWid;
		$fell(panelHsync) |-> wid_r == 11'((pan_r[26:16] - pan_r[10:0]) * PIX_DIV);
	endproperty
	a_panWid: assert property (p_panWid) else $error("panel sync width wrong");
	property p_fsOne;
		frameStart |=> !frameStart;
	endproperty
	a_fsOne: assert property (p_fsOne) else $error("frame pulse too long");
	property p_fsSync;
		frameStart |-> crtHsync;
	endproperty
	a_fsSync: assert property (p_fsSync) else $error("frame wrap off crt sync");
	c_frame: cover property (frameStart);
	c_panel: cover property ($fell(panelHsync));
	c_error: cover property (pslverr);
endmodule // dst_display_sync_timing_sva

bind dst_display_sync_timing dst_display_sync_timing_sva #(.PIX_DIV(PIX_DIV)) chk_u (
	.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.crtHsync(crtHsync), .panelHsync(panelHsync), .frameStart(frameStart),
	.lineActive(lineActive));

// ===== dst_display_model.sv
// display side monitor measuring sync pulses
`timescale 1ns/1ns
module dst_display_model (
	input wire logic clk_sys,
	input wire logic crtHsync,
	input wire logic panelHsync,
	input wire logic frameStart,
	input wire logic lineActive,
	output int period,
	output int crtWid,
	output int panWid,
	output int skew,
	output int lines,
	output int actCyc,
	output int frames
);
	int t, crtT, cc, pc, lc, ac;
	initial {t, crtT, cc, pc, lc, ac, period, crtWid, panWid, skew, lines, actCyc, frames} = '0;
	always @(posedge clk_sys) begin
		t <= t + 1;
		cc <= crtHsync ? cc + 1 : 0;
		pc <= panelHsync ? pc + 1 : 0;
		ac <= ac + int'(lineActive);
		if (crtHsync && cc == 0) begin
			period <= t - crtT;
			crtT <= t;
			lc <= lc + 1;
			skew <= panelHsync ? pc : -1;
		end
		if (!crtHsync && cc != 0) crtWid <= cc;
		if (!panelHsync && pc != 0) panWid <= pc;
		if (frameStart) begin
			lines <= lc;
			lc <= 0;
			actCyc <= ac;
			ac <= int'(lineActive);
			frames <= frames + 1;
		end
	end
endmodule // dst_display_model

// ===== dst_display_sync_timing_tb_top.sv
// self-checking bench for the display sync timing block
`timescale 1ns/1ns
module dst_display_sync_timing_tb_top;
	logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, crtHsync, panelHsync, frameStart;
	logic lineActive, er;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	int errors, n_checks, period, crtWid, panWid, skew, lines, actCyc, frames;
	dst_display_sync_timing dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .crtHsync(crtHsync), .panelHsync(panelHsync),
		.frameStart(frameStart), .lineActive(lineActive));
	dst_display_model disp_u (.clk_sys(clk_sys), .crtHsync(crtHsync), .panelHsync(panelHsync),
		.frameStart(frameStart), .lineActive(lineActive), .period(period), .crtWid(crtWid),
		.panWid(panWid), .skew(skew), .lines(lines), .actCyc(actCyc), .frames(frames));
	initial begin
		clk_sys = 1'h0;
		forever #5 clk_sys = ~clk_sys;
	end
	// ==========================================
	// shared tasks
	task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
		n_checks++;
		if (s !== x) begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, x, s);
		end
	endtask
	task final_report;
		$display("errors %0d checks %0d", errors, n_checks);
		if (errors == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task apb(input logic w, input logic [15:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int i;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'h1;
		i = 0;
		do begin
			@(posedge clk_sys);
			i++;
		end while (pready !== 1'h1 && i < 50);
		q = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (i >= 50) begin
			errors++;
			final_report;
		end
		@(posedge clk_sys);
	endtask
	// ==========================================
	// scenarios
	task t_regs;
		logic [15:0] ofs [3] = '{16'h8338, 16'h833C, 16'h8340};
		logic [31:0] msk [3] = '{32'h07F807F8, 32'h07FF07FF, 32'h07FF07FF};
		for (int k = 0; k < 3; k++) begin
			apb(1'h1, ofs[k], 32'h07FF07FF, rd, er);
			apb(1'h0, ofs[k], 32'h00000000, rd, er);
			chk("reg", rd, msk[k]);
		end
		apb(1'h0, 16'h8000, 32'h00000000, rd, er);
		chk("unmapped error", {31'h00000000, er}, 32'h00000001);
		chk("unmapped data", rd, 32'h00000000);
	endtask
	task t_scan;
		int i;
		apb(1'h1, 16'h8350, 32'h0000001F, rd, er);
		apb(1'h1, 16'h833C, 32'h000D0007, rd, er);
		apb(1'h1, 16'h8338, 32'h000F0007, rd, er);
		apb(1'h1, 16'h8340, 32'h00030001, rd, er);
		apb(1'h1, 16'h8354, 32'h00000001, rd, er);
		i = 0;
		while (frames < 3 && i < 3000) begin
			@(posedge clk_sys);
			i++;
		end
		if (i >= 3000) begin
			errors++;
			final_report;
		end
		chk("period", period, 32);
		chk("crt width", crtWid, 8);
		chk("panel width", panWid, 6);
		chk("crt vs panel", skew, 0);
		chk("lines", lines, 4);
		chk("active", actCyc, 64);
	endtask
	initial begin
		{rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
		errors = 0;
		n_checks = 0;
		repeat (16) @(posedge clk_sys);
		rst_n <= 1'h1;
		@(posedge clk_sys);
		t_regs;
		t_scan;
		final_report;
	end
endmodule // dst_display_sync_timing_tb_top
